// *** rtl/gvts_consts.vh ***
`ifndef GVTS_CONSTS_VH
`define GVTS_CONSTS_VH

// Host command port addresses
`define GVTS_ADDR_TGT1_LAST  4'h3
`define GVTS_ADDR_TGT2       4'h4
`define GVTS_ADDR_MODE       4'h5
`define GVTS_ADDR_CEIL1      4'h6
`define GVTS_ADDR_CEIL2      4'h7
`define GVTS_ADDR_LOCK       4'h8

// Mode register fields: {src2, src1, speed2, speed1}
`define GVTS_MODE_SPEED_LSB  0
`define GVTS_MODE_SRC_LSB    2
`define GVTS_MODE_RESET      4'h0

// Reset values
`define GVTS_TGT_RESET       8'h00
`define GVTS_CEIL_RESET      4'hF
`define GVTS_LOCK_RESET      1'b1

// Boot code decode
`define GVTS_BOOT_BASE       8'h80
`define GVTS_BOOT_OFF_FIRST  8'hFB

// Offset trim codes, 25 mV is four 6.25 mV steps
`define GVTS_TRIM_UP         2'h1
`define GVTS_TRIM_DOWN       2'h2
`define GVTS_TRIM_STEPS      8'h04
`define GVTS_LEVEL_MAX       8'hFF

// Ceiling floors in 6.25 mV steps below 1.55 V, selections 0..7
`define GVTS_CEIL_0          8'h78
`define GVTS_CEIL_1          8'h66
`define GVTS_CEIL_2          8'h54
`define GVTS_CEIL_3          8'h42
`define GVTS_CEIL_4          8'h30
`define GVTS_CEIL_5          8'h1E
`define GVTS_CEIL_6          8'h0C
`define GVTS_CEIL_HIGH       8'h00

// Serial frame bit times
`define GVTS_BIT_LAST_DATA   4'h8
`define GVTS_BIT_ACK         4'h9
`define GVTS_BIT_STOP        4'hA

// Wait cycles between 6.25 mV steps of the internal target
`define GVTS_FAST_STEP_CYC   8'h02
`define GVTS_SLOW_STEP_CYC   8'h08

`endif

// *** rtl/gvts_serial_rx.v ***
`timescale 1ns/1ps
`default_nettype none
`include "gvts_consts.vh"

module gvts_serial_rx (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rst,
  // Link pins
  input  wire       serialTargetClock,
  input  wire       serialTargetDataIn,
  output wire       serialTargetDataOut,
  output wire       serialTargetDataOe,
  // Received code
  output reg  [7:0] rxCode_reg,
  output reg        rxStrobe_reg
);

  localparam S_IDLE = 3'b001;
  localparam S_DATA = 3'b010;
  localparam S_TAIL = 3'b100;

  reg  [2:0] clkSync_reg;
  reg  [1:0] datSync_reg;
  reg  [2:0] state_reg;
  reg  [3:0] bitCnt_reg;
  reg  [7:0] shift_reg;
  reg        ackOe_reg;
  wire       clkRise = clkSync_reg[1] & ~clkSync_reg[2];
  wire       clkFall = ~clkSync_reg[1] & clkSync_reg[2];
  wire       dat     = datSync_reg[1];

  // The acknowledge is always a driven low
  assign serialTargetDataOut = 1'b0;
  assign serialTargetDataOe  = ackOe_reg;

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      clkSync_reg  <= 3'h0;
      datSync_reg  <= 2'h3;
      state_reg    <= S_IDLE;
      bitCnt_reg   <= 4'h0;
      shift_reg    <= 8'h00;
      rxCode_reg   <= 8'h00;
      rxStrobe_reg <= 1'b0;
      ackOe_reg    <= 1'b0;
    end
    else
    begin
      clkSync_reg  <= {clkSync_reg[1:0], serialTargetClock};
      datSync_reg  <= {datSync_reg[0], serialTargetDataIn};
      rxStrobe_reg <= 1'b0;
      // Drive on the falling edge so the line is settled before bit 9 is sampled
      if (clkFall)
        ackOe_reg <= (state_reg == S_TAIL) && (bitCnt_reg == `GVTS_BIT_ACK);
      if (clkRise)
      begin
        case (state_reg)
          S_IDLE:
          begin
            if (!dat)
            begin
              state_reg  <= S_DATA;
              bitCnt_reg <= 4'h1;
            end
          end
          S_DATA:
          begin
            shift_reg  <= {shift_reg[6:0], dat};
            bitCnt_reg <= bitCnt_reg + 4'h1;
            if (bitCnt_reg == `GVTS_BIT_LAST_DATA)
              state_reg <= S_TAIL;
          end
          S_TAIL:
          begin
            bitCnt_reg <= bitCnt_reg + 4'h1;
            if (bitCnt_reg == `GVTS_BIT_STOP)
            begin
              // A frame without a high stop bit is dropped
              state_reg    <= S_IDLE;
              rxStrobe_reg <= dat;
              if (dat)
                rxCode_reg <= shift_reg;
            end
          end
          default:
            state_reg <= S_IDLE;
        endcase
      end
    end
  end

endmodule // gvts_serial_rx

`default_nettype wire

// *** rtl/gvts_top.v ***
// Operation
// - Each loop keeps a speed bit (0 fast, 1 slow) and a source bit (0 boot, 1 registers), both zero after reset.
// - In pin-select mode a loop holds its boot code until the host sets its source to the registers.
// - Under register control loop 1 follows one of four registers picked by the two select pins.
// - Under register control loop 2 follows its own register and ignores the select pins.
// - Target registers are writable at any time and a write to the selected one takes effect at once.
// - Register and serial codes share one table where code 0 is 1.55 V and each step is 6.25 mV lower.
// - In serial mode a loop holds its boot code until power-ok is high and a valid code has arrived.
// - A serial frame has eleven bit times: start, eight code bits, acknowledge, stop.
// - In serial mode dropping power-ok sends each loop back to its boot code.
// - Power-good stays asserted while the loops return to a boot code below FBh after power-ok drops.
// - Each loop's effective target is clamped to its ceiling whatever the code and trim.
// - Each loop picks its ceiling from eight fixed values from 0.800 V to 1.550 V; selections 7 to 15 all give 1.550 V.
// - Ceiling writes are refused while the lock bit is one; the host unlocks, writes, then relocks.
// - Boot codes use a table where 80h is 1.55 V, each step is 12.5 mV lower and FBh to FFh mean off.
`timescale 1ns/1ps
`default_nettype none
`include "gvts_consts.vh"

module gvts_top (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rst,
  // Mode and select pins
  input  wire       pinSelectMode,
  input  wire       targetSelectHigh,
  input  wire       targetSelectLow,
  input  wire       platformPowerOk,
  // Serial target link
  input  wire       serialTargetClock,
  input  wire       serialTargetDataIn,
  output reg        serialTargetDataOut,
  output reg        serialTargetDataOe,
  // Host command port
  input  wire       hostWrite,
  input  wire [3:0] hostAddr,
  input  wire [7:0] hostData,
  // Stored boot codes and trims
  input  wire [7:0] bootCode1,
  input  wire [7:0] bootCode2,
  input  wire [1:0] offsetTrim1,
  input  wire [1:0] offsetTrim2,
  // Effective targets, in 6.25 mV steps below 1.55 V
  output wire [7:0] targetLevel1,
  output wire [7:0] targetLevel2,
  output wire       targetOff1,
  output wire       targetOff2,
  output wire       outputPowerGood1,
  output wire       outputPowerGood2,
  // Status
  output reg  [3:0] modeBits,
  output reg  [3:0] ceilingSel1,
  output reg  [3:0] ceilingSel2,
  output reg        ceilingLock
);

  reg  [1:0] pinSync_reg [0:3];
  reg  [7:0] tgt1_reg [0:3];
  reg  [7:0] tgt2_reg;
  reg  [7:0] serialCode_reg;
  reg        codeValid_reg;
  wire       serialMode = ~pinSync_reg[0][1];
  wire       selHigh    = pinSync_reg[1][1];
  wire       selLow     = pinSync_reg[2][1];
  wire       powerOk    = pinSync_reg[3][1];
  wire [3:0] pinIn      = {platformPowerOk, targetSelectLow, targetSelectHigh, pinSelectMode};
  wire [7:0] rxCode;
  wire       rxStrobe;
  wire       ackOut;
  wire       ackOe;
  wire [15:0] levelAll;
  wire [1:0] offAll;
  wire [1:0] goodAll;
  wire [7:0] tgt1Sel    = tgt1_reg[{selHigh, selLow}];

  // Two-stage synchronisers for the mode, select and power-ok pins
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1)
    begin : g_sync
      always @(posedge ref_clk or posedge rst)
      begin
        if (rst)
          pinSync_reg[p] <= 2'h0;
        else
          pinSync_reg[p] <= {pinSync_reg[p][0], pinIn[p]};
      end
    end
  endgenerate

  gvts_serial_rx u_rx (
    .ref_clk             (ref_clk),
    .rst                 (rst),
    .serialTargetClock   (serialTargetClock),
    .serialTargetDataIn  (serialTargetDataIn),
    .serialTargetDataOut (ackOut),
    .serialTargetDataOe  (ackOe),
    .rxCode_reg          (rxCode),
    .rxStrobe_reg        (rxStrobe)
  );

  // Host writes and the serial code store
  integer k;
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (k = 0; k < 4; k = k + 1)
        tgt1_reg[k] <= `GVTS_TGT_RESET;
      tgt2_reg            <= `GVTS_TGT_RESET;
      modeBits            <= `GVTS_MODE_RESET;
      ceilingSel1         <= `GVTS_CEIL_RESET;
      ceilingSel2         <= `GVTS_CEIL_RESET;
      ceilingLock         <= `GVTS_LOCK_RESET;
      serialCode_reg      <= 8'h00;
      codeValid_reg       <= 1'b0;
      serialTargetDataOut <= 1'b0;
      serialTargetDataOe  <= 1'b0;
    end
    else
    begin
      serialTargetDataOut <= ackOut;
      serialTargetDataOe  <= ackOe;
      if (hostWrite)
      begin
        if (hostAddr <= `GVTS_ADDR_TGT1_LAST)
          tgt1_reg[hostAddr[1:0]] <= hostData;
        if (hostAddr == `GVTS_ADDR_TGT2)
          tgt2_reg <= hostData;
        if (hostAddr == `GVTS_ADDR_MODE)
          modeBits <= hostData[3:0];
        if (hostAddr == `GVTS_ADDR_CEIL1 && !ceilingLock)
          ceilingSel1 <= hostData[3:0];
        if (hostAddr == `GVTS_ADDR_CEIL2 && !ceilingLock)
          ceilingSel2 <= hostData[3:0];
        if (hostAddr == `GVTS_ADDR_LOCK)
          ceilingLock <= hostData[0];
      end
      // A code is only honoured while power-ok stands
      if (!powerOk)
        codeValid_reg <= 1'b0;
      else if (rxStrobe)
      begin
        codeValid_reg  <= 1'b1;
        serialCode_reg <= rxCode;
      end
    end
  end

  // Ceiling selection to the lowest allowed level index
  function [7:0] ceilFloor;
    input [3:0] sel;
    begin
      case (sel)
        4'h0:    ceilFloor = `GVTS_CEIL_0;
        4'h1:    ceilFloor = `GVTS_CEIL_1;
        4'h2:    ceilFloor = `GVTS_CEIL_2;
        4'h3:    ceilFloor = `GVTS_CEIL_3;
        4'h4:    ceilFloor = `GVTS_CEIL_4;
        4'h5:    ceilFloor = `GVTS_CEIL_5;
        4'h6:    ceilFloor = `GVTS_CEIL_6;
        default: ceilFloor = `GVTS_CEIL_HIGH;
      endcase
    end
  endfunction

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_loop
      wire [7:0] boot    = (i == 0) ? bootCode1 : bootCode2;
      wire [1:0] trim    = (i == 0) ? offsetTrim1 : offsetTrim2;
      wire [3:0] ceilSel = (i == 0) ? ceilingSel1 : ceilingSel2;
      wire [7:0] regCode = (i == 0) ? tgt1Sel : tgt2_reg;
      wire       srcReg  = modeBits[`GVTS_MODE_SRC_LSB + i];
      wire       slow    = modeBits[`GVTS_MODE_SPEED_LSB + i];
      // Boot steps are twice the size of the shared table's steps
      wire       bootOff = boot >= `GVTS_BOOT_OFF_FIRST;
      wire [7:0] bootLvl = (boot < `GVTS_BOOT_BASE) ? 8'h00 :
                           {boot[6:0] - 7'h00, 1'b0};
      reg  [7:0] reqLvl;
      reg        reqOff;
      reg  [7:0] trimLvl;
      reg  [7:0] goalLvl;
      reg  [7:0] level_reg;
      reg  [7:0] stepCnt_reg;
      reg        off_reg;
      reg        good_reg;

      always @*
      begin
        reqLvl = bootLvl;
        reqOff = bootOff;
        if (serialMode)
        begin
          if (powerOk && codeValid_reg)
          begin
            reqLvl = serialCode_reg;
            reqOff = 1'b0;
          end
        end
        else if (srcReg)
        begin
          reqLvl = regCode;
          reqOff = 1'b0;
        end
        trimLvl = reqLvl;
        if (trim == `GVTS_TRIM_UP)
          trimLvl = (reqLvl < `GVTS_TRIM_STEPS) ? 8'h00 : reqLvl - `GVTS_TRIM_STEPS;
        else if (trim == `GVTS_TRIM_DOWN)
          trimLvl = (reqLvl > `GVTS_LEVEL_MAX - `GVTS_TRIM_STEPS) ?
                    `GVTS_LEVEL_MAX : reqLvl + `GVTS_TRIM_STEPS;
        // Higher index means lower voltage, so the ceiling is a floor on the index
        goalLvl = (trimLvl < ceilFloor(ceilSel)) ? ceilFloor(ceilSel) : trimLvl;
      end

      always @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          level_reg   <= 8'h00;
          stepCnt_reg <= 8'h00;
          off_reg     <= 1'b1;
          good_reg    <= 1'b0;
        end
        else
        begin
          off_reg <= reqOff;
          if (level_reg == goalLvl)
            stepCnt_reg <= 8'h00;
          else if (stepCnt_reg != 8'h00)
            stepCnt_reg <= stepCnt_reg - 8'h01;
          else
          begin
            stepCnt_reg <= slow ? `GVTS_SLOW_STEP_CYC : `GVTS_FAST_STEP_CYC;
            level_reg   <= (level_reg < goalLvl) ? level_reg + 8'h01 : level_reg - 8'h01;
          end
          // Once good, only an off request clears it, so a return to a boot code below FBh keeps it
          if (reqOff)
            good_reg <= 1'b0;
          else if (level_reg == goalLvl)
            good_reg <= 1'b1;
        end
      end

      assign levelAll[i*8 +: 8] = level_reg;
      assign offAll[i]          = off_reg;
      assign goodAll[i]         = good_reg;
    end
  endgenerate

  assign targetLevel1     = levelAll[7:0];
  assign targetLevel2     = levelAll[15:8];
  assign targetOff1       = offAll[0];
  assign targetOff2       = offAll[1];
  assign outputPowerGood1 = goodAll[0];
  assign outputPowerGood2 = goodAll[1];

endmodule // gvts_top

`default_nettype wire

// *** verification/gvts_top_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module gvts_top_monitor (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // Watched ports
  input wire logic       platformPowerOk,
  input wire logic       serialTargetDataOut,
  input wire logic       serialTargetDataOe,
  input wire logic       hostWrite,
  input wire logic [3:0] hostAddr,
  input wire logic [7:0] hostData,
  input wire logic [7:0] bootCode1,
  input wire logic [7:0] targetLevel1,
  input wire logic       outputPowerGood1,
  input wire logic [3:0] modeBits,
  input wire logic [3:0] ceilingSel1,
  input wire logic [3:0] ceilingSel2,
  input wire logic       ceilingLock
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_mode_write: assert property (hostWrite && hostAddr == 4'h5 |=> modeBits == $past(hostData[3:0]))
    else $error("mode bits not taken from write");
  a_lock_refuse: assert property (hostWrite && hostAddr == 4'h6 && ceilingLock |=> $stable(ceilingSel1))
    else $error("ceiling changed while locked");
  a_ceil_take: assert property (hostWrite && hostAddr == 4'h7 && !ceilingLock |=> ceilingSel2 == $past(hostData[3:0]))
    else $error("unlocked ceiling write lost");
  a_step_gap: assert property (!$stable(targetLevel1) |=> $stable(targetLevel1) [*2])
    else $error("fast step too close");
  a_slow_gap: assert property ($past(modeBits[0]) && !$stable(targetLevel1) |=> $stable(targetLevel1) [*8])
    else $error("slow step too close");
  a_ack_low: assert property (serialTargetDataOe |-> !serialTargetDataOut)
    else $error("acknowledge not driven low");
  a_ack_len: assert property ($rose(serialTargetDataOe) |=> serialTargetDataOe [*5] ##[1:6] !serialTargetDataOe)
    else $error("acknowledge drive length wrong");
  a_pg_hold: assert property ($fell(platformPowerOk) && outputPowerGood1 && bootCode1 < 8'hFB |=> outputPowerGood1 [*8])
    else $error("power good dropped on return to boot");
  a_clamp_hold: assert property (ceilingSel1 == 4'h0 && targetLevel1 >= 8'h78 |=> targetLevel1 >= 8'h78 || ceilingSel1 != 4'h0)
    else $error("level went above ceiling");
endmodule // gvts_top_monitor

bind gvts_top gvts_top_monitor mon (.ref_clk, .rst, .platformPowerOk, .serialTargetDataOut,
  .serialTargetDataOe, .hostWrite, .hostAddr, .hostData, .bootCode1, .targetLevel1,
  .outputPowerGood1, .modeBits, .ceilingSel1, .ceilingSel2, .ceilingLock);
`default_nettype wire

// *** verification/gvts_link_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module gvts_link_model (
  // Device side of the link
  input  wire logic dataOut,
  input  wire logic dataOe,
  output var  logic linkClk,
  output wire logic lineLevel,
  // Acknowledge of the last frame
  output var  logic ackSeen
);
  logic drv;
  logic bitv;
  // Pull-up: a released line reads high
  assign lineLevel = dataOe ? dataOut : (drv ? bitv : 1'b1);
  initial
  begin
    linkClk = 1'b0;
    drv = 1'b0;
    bitv = 1'b1;
    ackSeen = 1'b0;
  end
  // Clock stands low between frames
  task automatic send(input logic [7:0] code, input logic stopOk);
    logic [10:0] frame;
    frame = {1'b0, code, 1'b1, stopOk};
    ackSeen = 1'b0;
    #37;
    for (int i = 10; i >= 0; i--)
    begin
      drv = (i != 1);
      bitv = frame[i];
      #400;
      linkClk = 1'b1;
      #399;
      if (i == 1)
        ackSeen = !lineLevel;
      #1;
      linkClk = 1'b0;
    end
    drv = 1'b0;
  endtask
endmodule // gvts_link_model
`default_nettype wire

// *** verification/gvts_top_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin nErrors++; \
  $display("[FAIL] %0t act=%h exp=%h", $time, act, exp); end end
module gvts_top_tb_top;
  logic       ref_clk;
  logic       rst;
  logic       pinSelectMode;
  logic       targetSelectHigh;
  logic       targetSelectLow;
  logic       platformPowerOk;
  logic       hostWrite;
  logic [3:0] hostAddr;
  logic [7:0] hostData;
  logic [7:0] bootCode1;
  logic [7:0] bootCode2;
  logic [1:0] offsetTrim1;
  logic [1:0] offsetTrim2;
  wire        linkClk;
  wire        lineLevel;
  wire        dataOut;
  wire        dataOe;
  wire        ackSeen;
  wire  [7:0] targetLevel1;
  wire  [7:0] targetLevel2;
  wire        targetOff1;
  wire        targetOff2;
  wire        outputPowerGood1;
  wire        outputPowerGood2;
  wire  [3:0] modeBits;
  wire  [3:0] ceilingSel1;
  wire  [3:0] ceilingSel2;
  wire        ceilingLock;
  int         nErrors;
  int         checked;
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  gvts_top uut (.ref_clk(ref_clk), .rst(rst), .pinSelectMode(pinSelectMode),
    .targetSelectHigh(targetSelectHigh), .targetSelectLow(targetSelectLow),
    .platformPowerOk(platformPowerOk), .serialTargetClock(linkClk),
    .serialTargetDataIn(lineLevel), .serialTargetDataOut(dataOut), .serialTargetDataOe(dataOe),
    .hostWrite(hostWrite), .hostAddr(hostAddr), .hostData(hostData), .bootCode1(bootCode1),
    .bootCode2(bootCode2), .offsetTrim1(offsetTrim1), .offsetTrim2(offsetTrim2),
    .targetLevel1(targetLevel1), .targetLevel2(targetLevel2), .targetOff1(targetOff1),
    .targetOff2(targetOff2), .outputPowerGood1(outputPowerGood1),
    .outputPowerGood2(outputPowerGood2),
    .modeBits(modeBits), .ceilingSel1(ceilingSel1), .ceilingSel2(ceilingSel2),
    .ceilingLock(ceilingLock));
  gvts_link_model link (.dataOut(dataOut), .dataOe(dataOe), .linkClk(linkClk),
    .lineLevel(lineLevel), .ackSeen(ackSeen));
  task automatic summarize;
    if (nErrors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic hostWr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #10;
    hostWrite = 1'b1;
    hostAddr = a;
    hostData = d;
    @(posedge ref_clk);
    #10;
    hostWrite = 1'b0;
  endtask
  task automatic waitLvl(input logic [7:0] e1, input logic [7:0] e2);
    int n;
    n = 0;
    while (n < 600 && (targetLevel1 !== e1 || targetLevel2 !== e2))
    begin
      @(posedge ref_clk);
      #10;
      n++;
    end
    `CHK(targetLevel1, e1)
    `CHK(targetLevel2, e2)
    if (n == 600)
    begin
      nErrors++;
      summarize();
    end
  endtask
  initial
  begin
    #5000000;
    nErrors++;
    summarize();
  end
  initial
  begin
    nErrors = 0;
    checked = 0;
    rst = 1'b1;
    pinSelectMode = 1'b1;
    {targetSelectHigh, targetSelectLow} = 2'h0;
    platformPowerOk = 1'b0;
    {hostWrite, hostAddr, hostData} = 13'h0000;
    bootCode1 = 8'h84;
    bootCode2 = 8'h88;
    offsetTrim1 = 2'h0;
    offsetTrim2 = 2'h0;
    repeat (6) @(posedge ref_clk);
    #10;
    rst = 1'b0;
    `CHK(modeBits, 4'h0)
    `CHK({ceilingSel1, ceilingLock}, 5'h1F)
    waitLvl(8'h08, 8'h10);
    for (int i = 0; i < 4; i++)
      hostWr(i[3:0], 8'h10 * (i[7:0] + 8'h01));
    hostWr(4'h4, 8'h05);
    `CHK(targetLevel1, 8'h08)
    hostWr(4'h5, 8'h0C);
    for (int i = 0; i < 4; i++)
    begin
      {targetSelectHigh, targetSelectLow} = i[1:0];
      waitLvl(8'h10 * (i[7:0] + 8'h01), 8'h05);
    end
    hostWr(4'h3, 8'h3A);
    waitLvl(8'h3A, 8'h05);
    offsetTrim2 = 2'h2;
    waitLvl(8'h3A, 8'h09);
    hostWr(4'h5, 8'h0D);
    hostWr(4'h3, 8'h38);
    waitLvl(8'h38, 8'h09);
    hostWr(4'h5, 8'h0C);
    hostWr(4'h6, 8'h00);
    `CHK(ceilingSel1, 4'hF)
    hostWr(4'h8, 8'h00);
    hostWr(4'h6, 8'h00);
    hostWr(4'h7, 8'h03);
    hostWr(4'h8, 8'h01);
    `CHK({ceilingSel1, ceilingSel2, ceilingLock}, 9'h007)
    offsetTrim1 = 2'h1;
    waitLvl(8'h78, 8'h42);
    hostWr(4'h8, 8'h00);
    hostWr(4'h6, 8'h0F);
    hostWr(4'h7, 8'h0F);
    hostWr(4'h8, 8'h01);
    offsetTrim1 = 2'h0;
    offsetTrim2 = 2'h0;
    pinSelectMode = 1'b0;
    waitLvl(8'h08, 8'h10);
    link.send(8'h30, 1'b1);
    repeat (30) @(posedge ref_clk);
    #10;
    `CHK(targetLevel1, 8'h08)
    platformPowerOk = 1'b1;
    link.send(8'h30, 1'b0);
    repeat (30) @(posedge ref_clk);
    #10;
    `CHK(targetLevel1, 8'h08)
    link.send(8'h20, 1'b1);
    `CHK(ackSeen, 1'b1)
    waitLvl(8'h20, 8'h20);
    platformPowerOk = 1'b0;
    waitLvl(8'h08, 8'h10);
    `CHK(outputPowerGood1, 1'b1)
    `CHK(outputPowerGood2, 1'b1)
    pinSelectMode = 1'b1;
    hostWr(4'h5, 8'h04);
    bootCode2 = 8'hFB;
    repeat (3) @(posedge ref_clk);
    #10;
    `CHK(targetOff2, 1'b1)
    `CHK(targetOff1, 1'b0)
    summarize();
  end
endmodule // gvts_top_tb_top
`default_nettype wire
